// ---- include/afbp_pkg.sv ----
package afbp_pkg;
    localparam int DATA_W         = 8;
    localparam int RX_DEPTH       = 16;
    localparam int TX_DEPTH       = 16;
    localparam int SYNC_STAGES    = 2;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int BB_STROBE_NS   = 40;
    localparam int BB_STROBE_CYC  =
        (BB_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_FIFO     = 2'h1;
    localparam logic [1:0] MODE_BB_ASYNC = 2'h2;
    localparam logic [1:0] MODE_BB_SYNC  = 2'h3;
    typedef enum logic [1:0] {BB_IDLE, BB_WSTB, BB_RSTB} afbp_bb_t;
endpackage

// ---- verilog/afbp_sync.sv ----
`timescale 1ns/10ps
module afbp_sync
    import afbp_pkg::*;
#(
    parameter int W     = 1,
    parameter logic [W-1:0] INIT = '1
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // Two-stage synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ---- verilog/afbp_port.sv ----
`timescale 1ns/10ps
// Operation
// - The data bus is driven by the device only while the read strobe is low.
// - rx_data_avail_n is low only when a received byte is waiting.
// - After each read strobe rises the rx flag goes high, then low if more.
// - Both availability flags are undriven while in reset.
// - tx_space_avail_n is low only when the transmit buffer has room.
// - On read strobe fall the head byte is driven and held while low.
// - On read strobe rise the byte read is popped.
// - On write strobe fall the data bus byte is captured for transmit.
// - FIFO mode is selected per channel by a configuration value at start-up.
// - In suspend with wakeup enabled a send_now_wake_n pulse asks resume.
// - When powered a send_now_wake_n pulse flushes pending transmit data.
// - Bit-bang mode only samples the eight lines for the host; port_data_oe stays low, so bb_dir enables no driver.
// - Bit-bang has synchronous and asynchronous variants per channel.
// - bb_write_ind_n pulses low when new host data is loaded into port_data_out.
// - bb_read_ind_n rises when the lines have been sampled for the host.
module afbp_port
    import afbp_pkg::*;
#(
    parameter int RXD = RX_DEPTH,
    parameter int TXD = TX_DEPTH
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Configuration
    input  wire logic [1:0]        cfg_mode,
    input  wire logic              cfg_wake_en,
    input  wire logic              usb_powered_n,
    // Pins
    input  wire logic [DATA_W-1:0] port_data_in,
    output logic      [DATA_W-1:0] port_data_out,
    output logic                   port_data_oe,
    input  wire logic              read_strobe_n,
    input  wire logic              write_strobe_n,
    input  wire logic              send_now_wake_n,
    output logic                   rx_data_avail_n,
    output logic                   rx_data_avail_oe,
    output logic                   tx_space_avail_n,
    output logic                   tx_space_avail_oe,
    output logic                   bb_write_ind_n,
    output logic                   bb_read_ind_n,
    // USB side receive stream
    input  wire logic [DATA_W-1:0] usb_rx_data,
    input  wire logic              usb_rx_valid,
    output logic                   usb_rx_ready,
    // USB side transmit stream
    output logic      [DATA_W-1:0] usb_tx_data,
    output logic                   usb_tx_valid,
    input  wire logic              usb_tx_ready,
    // USB control
    output logic                   usb_flush,
    output logic                   usb_resume_req,
    // Bit-bang host side
    input  wire logic [DATA_W-1:0] bb_out_data,
    input  wire logic [DATA_W-1:0] bb_dir,
    input  wire logic              bb_out_valid,
    input  wire logic              bb_sample_req,
    output logic      [DATA_W-1:0] bb_in_data,
    output logic                   bb_in_valid
);
    localparam int RA = $clog2(RXD);
    localparam int TA = $clog2(TXD);

    logic [1:0]        mode;
    logic              rd_s, wr_s, wk_s, rd_q, wr_q, wk_q;
    logic [DATA_W-1:0] rx_mem [RXD];
    logic [DATA_W-1:0] tx_mem [TXD];
    logic [RA:0]       rx_wp, rx_rp;
    logic [TA:0]       tx_wp, tx_rp;
    logic              rx_empty, rx_full, tx_empty, tx_full;
    logic              rd_fall, rd_rise, wr_fall, wk_fall;
    logic              rx_block, fifo_on, bb_on;
    logic [DATA_W-1:0] bb_reg;
    logic [DATA_W-1:0] bb_oe;
    afbp_bb_t          bb_st;
    logic [1:0]        bb_cnt;

    // Start-up mode capture
    always_ff @(posedge clk)
    begin
        if (srst)
            mode <= MODE_OFF;
        else if (mode == MODE_OFF)
            mode <= cfg_mode;
    end
    assign fifo_on = (mode == MODE_FIFO);
    assign bb_on   = mode[1];

    // Strobe synchronisers
    afbp_sync #(.W(3), .INIT(3'h7)) u_sync
    (
        .clk  (clk),
        .srst (srst),
        .din  ({read_strobe_n, write_strobe_n, send_now_wake_n}),
        .dout ({rd_s, wr_s, wk_s})
    );

    always_ff @(posedge clk)
    begin
        if (srst)
            {rd_q, wr_q, wk_q} <= 3'h7;
        else
            {rd_q, wr_q, wk_q} <= {rd_s, wr_s, wk_s};
    end
    assign rd_fall = rd_q & ~rd_s;
    assign rd_rise = ~rd_q & rd_s;
    assign wr_fall = wr_q & ~wr_s;
    assign wk_fall = wk_q & ~wk_s;

    assign rx_empty = (rx_wp == rx_rp);
    assign rx_full  = (rx_wp[RA] != rx_rp[RA]) &&
                      (rx_wp[RA-1:0] == rx_rp[RA-1:0]);
    assign tx_empty = (tx_wp == tx_rp);
    assign tx_full  = (tx_wp[TA] != tx_rp[TA]) &&
                      (tx_wp[TA-1:0] == tx_rp[TA-1:0]);

    // Receive buffer
    assign usb_rx_ready = ~rx_full & ~srst;
    always_ff @(posedge clk)
    begin
        if (usb_rx_valid && usb_rx_ready)
            rx_mem[rx_wp[RA-1:0]] <= usb_rx_data;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_wp <= '0;
            rx_rp <= '0;
        end
        else
        begin
            if (usb_rx_valid && usb_rx_ready)
                rx_wp <= rx_wp + 1'b1;
            if (fifo_on && rd_rise && !rx_empty)
                rx_rp <= rx_rp + 1'b1;
        end
    end

    // Flag forced high for two cycles after each read rise
    always_ff @(posedge clk)
    begin
        rx_block <= ~srst & rd_rise;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
            rx_data_avail_n <= 1'b1;
        else
            rx_data_avail_n <= rx_empty | rx_block | rd_rise
                             | ~fifo_on;
    end
    always_ff @(posedge clk)
    begin
        tx_space_avail_n <= srst | tx_full | wr_fall | ~fifo_on;
    end
    assign rx_data_avail_oe  = ~srst & fifo_on;
    assign tx_space_avail_oe = ~srst & fifo_on;

    // Transmit buffer
    always_ff @(posedge clk)
    begin
        if (fifo_on && wr_fall && !tx_full)
            tx_mem[tx_wp[TA-1:0]] <= port_data_in;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_wp <= '0;
            tx_rp <= '0;
        end
        else
        begin
            if (fifo_on && wr_fall && !tx_full)
                tx_wp <= tx_wp + 1'b1;
            if (usb_tx_valid && usb_tx_ready)
                tx_rp <= tx_rp + 1'b1;
        end
    end
    assign usb_tx_valid = ~tx_empty;
    assign usb_tx_data  = tx_mem[tx_rp[TA-1:0]];

    // Send-now and wake requests
    always_ff @(posedge clk)
    begin
        usb_flush      <= ~srst & wk_fall & ~usb_powered_n;
        usb_resume_req <= ~srst & wk_fall & usb_powered_n & cfg_wake_en;
    end

    // Data bus drive
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            port_data_out <= '0;
            port_data_oe  <= 1'b0;
        end
        else if (fifo_on)
        begin
            port_data_oe <= ~rd_s;
            if (rd_fall)
                port_data_out <= rx_mem[rx_rp[RA-1:0]];
        end
        else if (bb_on)
        begin
            port_data_oe  <= 1'b0;
            if (bb_st == BB_IDLE && bb_out_valid)
                port_data_out <= bb_out_data;
            else
                port_data_out <= bb_reg;
        end
        else
            port_data_oe <= 1'b0;
    end

    // Bit-bang per-line enables
    always_ff @(posedge clk)
    begin
        if (srst)
            bb_oe <= '0;
        else
            bb_oe <= bb_on ? bb_dir : '0;
    end

    // Bit-bang strobes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bb_st          <= BB_IDLE;
            bb_cnt         <= '0;
            bb_reg         <= '0;
            bb_write_ind_n <= 1'b1;
            bb_read_ind_n  <= 1'b1;
            bb_in_data     <= '0;
            bb_in_valid    <= 1'b0;
        end
        else
        begin
            bb_in_valid <= 1'b0;
            unique case (bb_st)
                BB_IDLE:
                begin
                    if (bb_on && bb_out_valid)
                    begin
                        bb_reg         <= bb_out_data;
                        bb_write_ind_n <= 1'b0;
                        bb_cnt         <= 2'(BB_STROBE_CYC);
                        bb_st          <= BB_WSTB;
                    end
                    else if (bb_on && bb_sample_req)
                    begin
                        bb_read_ind_n <= 1'b0;
                        bb_cnt        <= 2'(BB_STROBE_CYC);
                        bb_st         <= BB_RSTB;
                    end
                end
                BB_WSTB:
                begin
                    bb_cnt <= bb_cnt - 1'b1;
                    if (bb_cnt == 2'h1)
                    begin
                        bb_write_ind_n <= 1'b1;
                        // Sync variant samples after each write
                        if (mode == MODE_BB_SYNC)
                        begin
                            bb_read_ind_n <= 1'b0;
                            bb_cnt        <= 2'(BB_STROBE_CYC);
                            bb_st         <= BB_RSTB;
                        end
                        else
                            bb_st <= BB_IDLE;
                    end
                end
                BB_RSTB:
                begin
                    bb_cnt <= bb_cnt - 1'b1;
                    if (bb_cnt == 2'h1)
                    begin
                        bb_in_data    <= port_data_in;
                        bb_in_valid   <= 1'b1;
                        bb_read_ind_n <= 1'b1;
                        bb_st         <= BB_IDLE;
                    end
                end
            endcase
        end
    end

    // Assertions
    chk_flags_reset: assert property (@(posedge clk)
        srst |-> !rx_data_avail_oe && !tx_space_avail_oe)
        else $error("flags driven in reset");
    chk_bus_read_only: assert property (@(posedge clk) disable iff (srst)
        port_data_oe |-> $past(!rd_s))
        else $error("bus driven without read strobe");
    chk_rx_empty_flag: assert property (@(posedge clk) disable iff (srst)
        $past(rx_empty) |-> rx_data_avail_n)
        else $error("rx flag low while empty");
    chk_rx_after_rise: assert property (@(posedge clk) disable iff (srst)
        rd_rise |=> rx_data_avail_n ##1 rx_data_avail_n)
        else $error("rx flag not forced high");
    chk_tx_full_flag: assert property (@(posedge clk) disable iff (srst)
        $past(tx_full) |-> tx_space_avail_n)
        else $error("tx flag low while full");
    chk_pop_on_rise: assert property (@(posedge clk) disable iff (srst)
        fifo_on && rd_rise && !rx_empty |=> rx_rp == $past(rx_rp) + 1'b1)
        else $error("no pop on read rise");
    chk_push_on_fall: assert property (@(posedge clk) disable iff (srst)
        fifo_on && wr_fall && !tx_full |=> tx_wp == $past(tx_wp) + 1'b1)
        else $error("no capture on write fall");
    chk_wake_resume: assert property (@(posedge clk) disable iff (srst)
        wk_fall && usb_powered_n && cfg_wake_en |=> usb_resume_req)
        else $error("resume not requested");
    chk_flush_send: assert property (@(posedge clk) disable iff (srst)
        wk_fall && !usb_powered_n |=> usb_flush && !usb_resume_req)
        else $error("flush not requested");
    sequence s_wr_pulse;
        !bb_write_ind_n [*2] ##1 bb_write_ind_n;
    endsequence
    chk_bb_write_ind: assert property (@(posedge clk) disable iff (srst)
        $fell(bb_write_ind_n) |-> s_wr_pulse)
        else $error("bad write indication pulse");
    chk_bb_read_ind: assert property (@(posedge clk) disable iff (srst)
        $rose(bb_read_ind_n) |-> bb_in_valid)
        else $error("read indication without sample");
    chk_sync_delay: assert property (@(posedge clk) disable iff (srst)
        $fell(read_strobe_n) && rd_s |-> ##2 !rd_s)
        else $error("strobe sync latency");
endmodule

// ---- sim/afbp_host_model.sv ----
`timescale 1ns/10ps
module afbp_host_model
    import afbp_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Device pins
    input  wire logic [DATA_W-1:0] port_data_out,
    input  wire logic              port_data_oe,
    input  wire logic              rx_data_avail_n,
    input  wire logic              tx_space_avail_n,
    output logic      [DATA_W-1:0] port_data_in,
    output logic                   read_strobe_n,
    output logic                   write_strobe_n
);
    logic [DATA_W-1:0] drv_val;
    logic              drv_en;
    logic [DATA_W-1:0] last_val;

    initial
    begin
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        drv_en = 1'b0;
        drv_val = '0;
        last_val = '0;
    end

    // Bus level; a released bus keeps changing
    assign port_data_in = port_data_oe ? port_data_out :
        (drv_en ? drv_val : ~last_val);
    always @(posedge clk)
        last_val <= port_data_in;

    task automatic put(input logic [DATA_W-1:0] v);
        drv_val <= v;
        drv_en <= 1'b1;
    endtask

    task automatic rd(output logic [DATA_W-1:0] v, output bit ok);
        @(posedge clk);
        for (int n = 0; n < 200 && rx_data_avail_n !== 1'b0; n++)
            @(posedge clk);
        ok = (rx_data_avail_n === 1'b0);
        v = '0;
        if (ok)
        begin
            drv_en <= 1'b0;
            read_strobe_n <= 1'b0;
            repeat (5) @(posedge clk);
            v = port_data_in;
            read_strobe_n <= 1'b1;
            repeat (6) @(posedge clk);
        end
    endtask

    task automatic wr(input logic [DATA_W-1:0] v, output bit ok);
        @(posedge clk);
        for (int n = 0; n < 200 && tx_space_avail_n !== 1'b0; n++)
            @(posedge clk);
        ok = (tx_space_avail_n === 1'b0);
        if (ok)
        begin
            drv_val <= v;
            drv_en <= 1'b1;
            write_strobe_n <= 1'b0;
            repeat (5) @(posedge clk);
            write_strobe_n <= 1'b1;
            repeat (4) @(posedge clk);
            drv_en <= 1'b0;
        end
    endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/10ps
module tb
    import afbp_pkg::*;
;
    localparam int TXN = 4;
    logic              clk, srst, cfg_wake_en, usb_powered_n;
    logic [1:0]        cfg_mode;
    logic [DATA_W-1:0] port_data_in, port_data_out, usb_rx_data, usb_tx_data;
    logic [DATA_W-1:0] bb_out_data, bb_dir, bb_in_data, b;
    logic              port_data_oe, read_strobe_n, write_strobe_n;
    logic              send_now_wake_n, rx_data_avail_n, rx_data_avail_oe;
    logic              tx_space_avail_n, tx_space_avail_oe, bb_write_ind_n;
    logic              bb_read_ind_n, usb_rx_valid, usb_rx_ready, usb_tx_valid;
    logic              usb_tx_ready, usb_flush, usb_resume_req, bb_out_valid;
    logic              bb_sample_req, bb_in_valid;
    int                miscompares, total_checks, n;
    bit                ok;

    afbp_port #(.RXD(16), .TXD(TXN)) dut (.clk, .srst, .cfg_mode,
        .cfg_wake_en, .usb_powered_n, .port_data_in, .port_data_out,
        .port_data_oe, .read_strobe_n, .write_strobe_n, .send_now_wake_n,
        .rx_data_avail_n, .rx_data_avail_oe, .tx_space_avail_n,
        .tx_space_avail_oe, .bb_write_ind_n, .bb_read_ind_n, .usb_rx_data,
        .usb_rx_valid, .usb_rx_ready, .usb_tx_data, .usb_tx_valid,
        .usb_tx_ready, .usb_flush, .usb_resume_req, .bb_out_data, .bb_dir,
        .bb_out_valid, .bb_sample_req, .bb_in_data, .bb_in_valid);
    afbp_host_model host (.clk, .port_data_out, .port_data_oe,
        .rx_data_avail_n, .tx_space_avail_n, .port_data_in, .read_strobe_n,
        .write_strobe_n);

    always #10 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic give_up();
        miscompares++;
        end_of_test();
    endtask
    task automatic do_reset(input logic [1:0] mode);
        @(posedge clk);
        srst <= 1'b1;
        cfg_mode <= mode;
        repeat (5) @(posedge clk);
        chk(rx_data_avail_oe, 1'b0);
        chk(tx_space_avail_oe, 1'b0);
        chk(port_data_oe, 1'b0);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic push(input logic [7:0] v);
        @(posedge clk);
        usb_rx_data <= v;
        usb_rx_valid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (usb_rx_ready === 1'b1)
                break;
        end
        if (usb_rx_ready !== 1'b1)
            give_up();
        usb_rx_valid <= 1'b0;
    endtask
    task automatic pull(input logic [7:0] exp);
        @(posedge clk);
        usb_tx_ready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (usb_tx_valid === 1'b1)
                break;
        end
        if (usb_tx_valid !== 1'b1)
            give_up();
        chk(usb_tx_data, exp);
        usb_tx_ready <= 1'b0;
    endtask
    task automatic wake(input logic pw, en, fl, rs);
        logic sf, sr;
        sf = 1'b0;
        sr = 1'b0;
        @(posedge clk);
        usb_powered_n <= pw;
        cfg_wake_en <= en;
        repeat (2) @(posedge clk);
        send_now_wake_n <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            if (i == 4)
                send_now_wake_n <= 1'b1;
            sf = sf | (usb_flush === 1'b1);
            sr = sr | (usb_resume_req === 1'b1);
        end
        chk(sf, fl);
        chk(sr, rs);
    endtask

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        cfg_mode = MODE_OFF;
        cfg_wake_en = 1'b0;
        usb_powered_n = 1'b0;
        send_now_wake_n = 1'b1;
        usb_rx_data = '0;
        usb_rx_valid = 1'b0;
        usb_tx_ready = 1'b0;
        bb_out_data = '0;
        bb_dir = 8'h00;
        bb_out_valid = 1'b0;
        bb_sample_req = 1'b0;
        miscompares = 0;
        total_checks = 0;
        do_reset(MODE_FIFO);
        chk(rx_data_avail_n, 1'b1);
        chk(tx_space_avail_n, 1'b0);
        chk(rx_data_avail_oe, 1'b1);
        chk(tx_space_avail_oe, 1'b1);
        for (int i = 0; i < 3; i++)
            push(8'hA0 + 8'(i));
        repeat (3) @(posedge clk);
        chk(rx_data_avail_n, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            host.rd(b, ok);
            if (!ok)
                give_up();
            chk(b, 8'hA0 + 8'(i));
        end
        chk(rx_data_avail_n, 1'b1);
        for (int i = 0; i < TXN; i++)
        begin
            host.wr(8'h50 + 8'(i), ok);
            if (!ok)
                give_up();
        end
        chk(tx_space_avail_n, 1'b1);
        chk(port_data_oe, 1'b0);
        for (int i = 0; i < TXN; i++)
            pull(8'h50 + 8'(i));
        repeat (4) @(posedge clk);
        chk(tx_space_avail_n, 1'b0);
        wake(1'b0, 1'b1, 1'b1, 1'b0);
        wake(1'b1, 1'b1, 1'b0, 1'b1);
        wake(1'b1, 1'b0, 1'b0, 1'b0);
        for (logic [7:0] m = 8'h02; m < 8'h04; m++)
        begin
            do_reset(m[1:0]);
            chk(rx_data_avail_oe, 1'b0);
            host.put(8'hC0 | m);
            @(posedge clk);
            bb_out_data <= 8'h30 | m;
            bb_out_valid <= 1'b1;
            @(posedge clk);
            bb_out_valid <= 1'b0;
            for (n = 0; n < 8 && bb_write_ind_n !== 1'b0; n++)
                @(posedge clk);
            chk(bb_write_ind_n, 1'b0);
            chk(port_data_out, 8'h30 | m);
            chk(port_data_oe, 1'b0);
            bb_sample_req <= (m == 8'h02);
            for (n = 0; n < 8 && bb_read_ind_n !== 1'b0; n++)
                @(posedge clk);
            chk(bb_read_ind_n, 1'b0);
            bb_sample_req <= 1'b0;
            for (n = 0; n < 12 && bb_in_valid !== 1'b1; n++)
                @(posedge clk);
            chk(bb_in_data, 8'hC0 | m);
            chk(bb_read_ind_n, 1'b1);
        end
        end_of_test();
    end
endmodule
